// [rtl/serial_port_pkg.sv]
package serial_port_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int         ADDR_W            = 5;
	localparam logic [4:0] SPC_ADDR          = 5'h18;
	localparam logic [4:0] REV_ADDR          = 5'h1F;
	localparam logic [7:0] SPC_RESET         = 8'h00;
	localparam logic [7:0] SPC_WRITE_MASK    = 8'hE7;
	localparam logic [7:0] UNMAPPED_READ     = 8'h00;
	// Arbitrary neutral value; the real part code is deliberately not used.
	localparam logic [7:0] REV_ID_DEFAULT    = 8'h5A;

	// ****************************************************************
	// Control field positions (each function sits twice, mirrored)
	// ****************************************************************
	localparam int ORDER_HI   = 7;
	localparam int ORDER_LO   = 0;
	localparam int WIRE_HI    = 6;
	localparam int WIRE_LO    = 1;
	localparam int RELEASE_HI = 5;
	localparam int RELEASE_LO = 2;

	// ****************************************************************
	// Instruction byte fields
	// ****************************************************************
	localparam int INSTR_CMD_BIT  = 7;
	localparam int INSTR_READ_BIT = 6;
	localparam int INSTR_WORD_BIT = 5;
	localparam logic [2:0] LAST_BIT_IDX = 3'h7;
	localparam logic [2:0] FIRST_BIT_IDX = 3'h0;

	// ****************************************************************
	// Synchroniser
	// ****************************************************************
	localparam int PIN_COUNT = 3;

	typedef struct packed {
		logic lsb_first;
		logic wire_count_select;
		logic early_release;
	} port_cfg_t;

	typedef enum {PH_INSTR, PH_WRITE, PH_READ, PH_IGNORE} phase_t;

	function automatic port_cfg_t cfg_of(input logic [7:0] r);
		port_cfg_t c;
		c.lsb_first         = r[ORDER_HI] | r[ORDER_LO];
		c.wire_count_select = r[WIRE_HI] | r[WIRE_LO];
		c.early_release     = r[RELEASE_HI] | r[RELEASE_LO];
		return c;
	endfunction : cfg_of

	// Bit that travels in slot idx of a byte for the given order.
	function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] idx,
		input logic lsb);
		return lsb ? b[idx] : b[3'h7 - idx];
	endfunction : pick_bit

endpackage : serial_port_pkg

// [rtl/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             REF_CLK_IN,
	input  wire logic             RSTN_IN,
	input  wire logic [WIDTH-1:0] ASYNC_IN,
	input  wire logic [WIDTH-1:0] RESET_VAL_IN,
	output logic      [WIDTH-1:0] SYNC_OUT
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;
	logic [1:0]       primed_q;

	// ****************************************************************
	// Two-flop crossing
	// ****************************************************************
	// The reset value port only steers the output until both stages hold pin samples,
	// so the flops themselves reset to constants and no false level leaks out.
	always_comb begin
		meta_d = ASYNC_IN;
		sync_d = meta_q;
	end

	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			meta_q   <= '0;
			sync_q   <= '0;
			primed_q <= 2'h0;
		end else begin
			meta_q   <= meta_d;
			sync_q   <= sync_d;
			primed_q <= {primed_q[0], 1'b1};
		end
	end

	assign SYNC_OUT = primed_q[1] ? sync_q : RESET_VAL_IN;

endmodule : pin_sync

// [rtl/serial_port_config.sv]
// Operation
// - Each control bit is held twice in the control register, mirrored about its centre.
// - A function is on when either of its two mirrored copies is set.
// - The control register sits at address 24 and is written and read serially.
// - The write instruction 0001 1000 to address 24 decodes in either bit order.
// - Bit order 1 shifts bytes least significant bit first, 0 (reset) most first.
// - In two-wire mode the data input pin drives out during the read data phase only.
// - In two-wire mode what goes out on the data input pin also goes out on data output.
// - In three-wire mode data is received on data input and sent on data output only.
// - With early release set the driven line floats on the last active edge of the last byte.
// - With early release clear the line floats on the next inactive edge or chip select high.
// - The data output pin floats at the same moment whatever the wire mode.
// - A read-only revision register at address 31 holds a fixed revision code.
`timescale 1ns/100ps
module serial_port_config
	import serial_port_pkg::*;
#(
	parameter logic [7:0] REVISION_ID = REV_ID_DEFAULT
) (
	input  wire logic REF_CLK_IN,
	input  wire logic RSTN_IN,
	input  wire logic SCLK_IN,
	input  wire logic CS_N_IN,
	input  wire logic DIN_IN,
	output logic      DIN_OUT,
	output logic      DIN_OE_N_OUT,
	output logic      DOUT_OUT,
	output logic      DOUT_OE_N_OUT,
	output logic      LSB_FIRST_OUT,
	output logic      WIRE_COUNT_SELECT_OUT,
	output logic      EARLY_RELEASE_OUT
);

	// ****************************************************************
	// Pin crossing and edge detection
	// ****************************************************************
	logic [PIN_COUNT-1:0] pins_s;
	logic                 sclk_s;
	logic                 cs_n_s;
	logic                 din_s;
	logic                 sclk_prev_q;
	logic                 sclk_rise;
	logic                 sclk_fall;

	pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_sync (
		.REF_CLK_IN  (REF_CLK_IN),
		.RSTN_IN     (RSTN_IN),
		.ASYNC_IN    ({SCLK_IN, CS_N_IN, DIN_IN}),
		.RESET_VAL_IN({1'b0, 1'b1, 1'b0}),
		.SYNC_OUT    (pins_s)
	);

	assign sclk_s    = pins_s[2];
	assign cs_n_s    = pins_s[1];
	assign din_s     = pins_s[0];
	// Active edge is the rising one; data is sampled there and changed on the falling one, except the first bit of a read byte, set on the active edge before it.
	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;

	// ****************************************************************
	// Transfer state
	// ****************************************************************
	phase_t            phase_q;
	phase_t            phase_d;
	logic [2:0]        cnt_q;
	logic [2:0]        cnt_d;
	logic [7:0]        shift_q;
	logic [7:0]        shift_d;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	logic              word_q;
	logic              word_d;
	logic              second_q;
	logic              second_d;
	logic [7:0]        tx_q;
	logic [7:0]        tx_d;
	logic              out_bit_q;
	logic              out_bit_d;
	logic              drive_q;
	logic              drive_d;
	logic              hold_q;
	logic              hold_d;
	logic [7:0]        spc_q;
	logic [7:0]        spc_d;
	port_cfg_t         cfg_q;
	port_cfg_t         cfg_d;
	logic [7:0]        rx_byte;
	logic [7:0]        next_tx;
	logic [ADDR_W-1:0] next_addr;

	function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a,
		input logic [7:0] spc);
		logic [7:0] v;
		v = UNMAPPED_READ;
		if (a == SPC_ADDR) begin
			v = spc;
		end else if (a == REV_ADDR) begin
			v = REVISION_ID;
		end
		return v;
	endfunction : reg_read

	always_comb begin
		phase_d   = phase_q;
		cnt_d     = cnt_q;
		shift_d   = shift_q;
		addr_d    = addr_q;
		word_d    = word_q;
		second_d  = second_q;
		tx_d      = tx_q;
		out_bit_d = out_bit_q;
		drive_d   = drive_q;
		hold_d    = hold_q;
		spc_d     = spc_q;
		cfg_d     = cfg_q;
		rx_byte   = cfg_q.lsb_first ? {din_s, shift_q[7:1]} : {shift_q[6:0], din_s};
		next_addr = addr_q + 5'h01;
		next_tx   = reg_read(next_addr, spc_q);
		if (cs_n_s) begin
			// Chip select high ends any transfer and floats both lines at once.
			phase_d  = PH_INSTR;
			cnt_d    = FIRST_BIT_IDX;
			second_d = 1'b0;
			drive_d  = 1'b0;
			hold_d   = 1'b0;
		end else if (sclk_fall) begin
			if (hold_q) begin
				drive_d = 1'b0;
				hold_d  = 1'b0;
			end else if (drive_q && cnt_q != FIRST_BIT_IDX) begin
				out_bit_d = pick_bit(tx_q, cnt_q, cfg_q.lsb_first);
			end
		end else if (sclk_rise) begin
			shift_d = rx_byte;
			cnt_d   = cnt_q + 3'h1;
			if (cnt_q == LAST_BIT_IDX) begin
				unique case (phase_q)
					PH_INSTR: begin
						// Decodes the same in either order because 0001 1000 is symmetric.
						if (!rx_byte[INSTR_CMD_BIT]) begin
							addr_d = rx_byte[ADDR_W-1:0];
							word_d = rx_byte[INSTR_WORD_BIT];
							if (rx_byte[INSTR_READ_BIT]) begin
								phase_d   = PH_READ;
								tx_d      = reg_read(rx_byte[ADDR_W-1:0], spc_q);
								out_bit_d = pick_bit(tx_d, FIRST_BIT_IDX, cfg_q.lsb_first);
								drive_d   = 1'b1;
							end else begin
								phase_d = PH_WRITE;
							end
						end else begin
							phase_d = PH_IGNORE;
						end
					end
					PH_WRITE: begin
						if (addr_q == SPC_ADDR) begin
							// Reserved middle bits are kept clear even if the host errs.
							spc_d = rx_byte & SPC_WRITE_MASK;
							// Taken only after the byte completes, so it shapes the next one.
							cfg_d = cfg_of(spc_d);
						end
						if (word_q && !second_q) begin
							second_d = 1'b1;
							addr_d   = next_addr;
						end else begin
							phase_d = PH_IGNORE;
						end
					end
					PH_READ: begin
						if (word_q && !second_q) begin
							second_d  = 1'b1;
							addr_d    = next_addr;
							tx_d      = next_tx;
							out_bit_d = pick_bit(next_tx, FIRST_BIT_IDX, cfg_q.lsb_first);
						end else begin
							phase_d = PH_IGNORE;
							if (cfg_q.early_release) begin
								drive_d = 1'b0;
							end else begin
								hold_d = 1'b1;
							end
						end
					end
					PH_IGNORE: begin
						phase_d = PH_IGNORE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			sclk_prev_q <= 1'b0;
			phase_q     <= PH_INSTR;
			cnt_q       <= FIRST_BIT_IDX;
			shift_q     <= 8'h00;
			addr_q      <= 5'h00;
			word_q      <= 1'b0;
			second_q    <= 1'b0;
			tx_q        <= 8'h00;
			out_bit_q   <= 1'b0;
			drive_q     <= 1'b0;
			hold_q      <= 1'b0;
			spc_q       <= SPC_RESET;
			cfg_q       <= '0;
		end else begin
			sclk_prev_q <= sclk_s;
			phase_q     <= phase_d;
			cnt_q       <= cnt_d;
			shift_q     <= shift_d;
			addr_q      <= addr_d;
			word_q      <= word_d;
			second_q    <= second_d;
			tx_q        <= tx_d;
			out_bit_q   <= out_bit_d;
			drive_q     <= drive_d;
			hold_q      <= hold_d;
			spc_q       <= spc_d;
			cfg_q       <= cfg_d;
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	// Both pins carry the same bit and share the drive_q enable, gated by two-wire mode on the data input pin, so in that mode they float together.
	assign DOUT_OUT              = out_bit_q;
	assign DOUT_OE_N_OUT         = ~drive_q;
	assign DIN_OUT               = out_bit_q;
	assign DIN_OE_N_OUT          = ~(drive_q & cfg_q.wire_count_select);
	assign LSB_FIRST_OUT         = cfg_q.lsb_first;
	assign WIRE_COUNT_SELECT_OUT = cfg_q.wire_count_select;
	assign EARLY_RELEASE_OUT     = cfg_q.early_release;

endmodule : serial_port_config

// [tb/serial_port_config_properties.sv]
`timescale 1ns/100ps
module serial_port_config_checks (
	input wire logic REF_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic SCLK_IN,
	input wire logic CS_N_IN,
	input wire logic DIN_IN,
	input wire logic DIN_OUT,
	input wire logic DIN_OE_N_OUT,
	input wire logic DOUT_OUT,
	input wire logic DOUT_OE_N_OUT,
	input wire logic LSB_FIRST_OUT,
	input wire logic WIRE_COUNT_SELECT_OUT,
	input wire logic EARLY_RELEASE_OUT
);
	// ****************************************************************
	// Port behaviour
	// ****************************************************************
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	sequence cs_idle_s;
		CS_N_IN [*6];
	endsequence
	sequence din_driven_s;
		!DIN_OE_N_OUT;
	endsequence
	reset_defaults_a: assert property ($rose(RSTN_IN) |->
		{LSB_FIRST_OUT, WIRE_COUNT_SELECT_OUT, EARLY_RELEASE_OUT, DIN_OE_N_OUT,
		DOUT_OE_N_OUT} == 5'h03) else $error("reset defaults wrong");
	din_drive_a: assert property (din_driven_s |->
		WIRE_COUNT_SELECT_OUT && !DOUT_OE_N_OUT) else $error("data in driven wrongly");
	din_mirror_a: assert property (din_driven_s |-> DIN_OUT == DOUT_OUT)
		else $error("two wire copy differs");
	three_wire_a: assert property (!WIRE_COUNT_SELECT_OUT |-> DIN_OE_N_OUT)
		else $error("data in driven in three wire mode");
	release_pair_a: assert property (
		$rose(DOUT_OE_N_OUT) && WIRE_COUNT_SELECT_OUT |-> $rose(DIN_OE_N_OUT))
		else $error("release moments differ");
	cs_release_a: assert property (cs_idle_s |-> DOUT_OE_N_OUT && DIN_OE_N_OUT)
		else $error("driving while deselected");
	cfg_update_a: assert property (
		$changed({LSB_FIRST_OUT, WIRE_COUNT_SELECT_OUT, EARLY_RELEASE_OUT})
		|-> !$past(CS_N_IN, 4)) else $error("settings changed outside frame");
	data_stands_a: assert property (
		$changed(DOUT_OUT) && !DOUT_OE_N_OUT && !$past(DOUT_OE_N_OUT)
		|-> !$past(SCLK_IN, 2)) else $error("data bit moved early");
endmodule : serial_port_config_checks

bind serial_port_config serial_port_config_checks u_checks (
	.REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .SCLK_IN(SCLK_IN),
	.CS_N_IN(CS_N_IN), .DIN_IN(DIN_IN), .DIN_OUT(DIN_OUT),
	.DIN_OE_N_OUT(DIN_OE_N_OUT), .DOUT_OUT(DOUT_OUT), .DOUT_OE_N_OUT(DOUT_OE_N_OUT),
	.LSB_FIRST_OUT(LSB_FIRST_OUT), .WIRE_COUNT_SELECT_OUT(WIRE_COUNT_SELECT_OUT),
	.EARLY_RELEASE_OUT(EARLY_RELEASE_OUT));

// [tb/serial_host_model.sv]
`timescale 1ns/100ps
module serial_host_model (
	input  wire logic clk_in,
	input  wire logic din_wire_in,
	input  wire logic dout_in,
	input  wire logic dout_oe_n_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      din_out,
	output logic      din_oe_n_out
);
	// ****************************************************************
	// Host frame
	// ****************************************************************
	logic lsb;
	logic two_w;
	logic cut;
	initial begin
		{lsb, two_w, cut, sclk_out, din_out, din_oe_n_out} = 6'h00;
		cs_n_out = 1'b1;
	end
	// Read data is taken at each active edge; the release flag is taken at the end of the
	// last high phase, so an early release is told apart from a late one.
	// With cut set the clock stays high after the last byte, so only chip select can free it.
	task automatic frame(input logic [7:0] ins, input logic [7:0] wd,
		output logic [7:0] rd, output logic late);
		logic [15:0] tx;
		logic [15:0] s;
		logic [7:0]  bv;
		tx = {ins, (ins == 8'h18) ? (wd & 8'hE7) : wd};
		cs_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (int j = 0; j < 16; j++) begin
			bv = (j < 8) ? tx[15:8] : tx[7:0];
			din_out <= lsb ? bv[j % 8] : bv[7 - j % 8];
			repeat (4) @(posedge clk_in);
			s[j] = two_w ? din_wire_in : dout_in;
			sclk_out <= 1'b1;
			repeat (2) @(posedge clk_in);
			if (j == 7) din_oe_n_out <= ins[6] & two_w;
			repeat (2) @(posedge clk_in);
			late = dout_oe_n_in;
			if (j < 15 || !cut) sclk_out <= 1'b0;
		end
		repeat (8) @(posedge clk_in);
		cs_n_out     <= 1'b1;
		din_oe_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		sclk_out     <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (int i = 0; i < 8; i++) rd[lsb ? i : 7 - i] = s[8 + i];
	endtask : frame
endmodule : serial_host_model

// [tb/serial_port_config_bench.sv]
`timescale 1ns/100ps
module serial_port_config_bench
	import serial_port_pkg::*;
;
	// ****************************************************************
	// Bench
	// ****************************************************************
	logic ref_clk = 1'b0;
	logic rstn    = 1'b0;
	logic sclk, cs_n, host_din, host_oe_n;
	logic din_o, din_oe_n, dout_o, dout_oe_n, lsb_o, wire_o, early_o;
	// A line nobody drives shows the inverse of its last value, never a lucky match.
	wire  din_wire  = !din_oe_n ? din_o : (host_oe_n ? ~host_din : host_din);
	wire  dout_wire = dout_oe_n ? ~dout_o : dout_o;
	int   miscompares = 0;
	int   compares    = 0;
	int   pos [6]     = '{7, 0, 6, 1, 5, 2};
	serial_port_config u_dut (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .SCLK_IN(sclk),
		.CS_N_IN(cs_n), .DIN_IN(din_wire), .DIN_OUT(din_o), .DIN_OE_N_OUT(din_oe_n),
		.DOUT_OUT(dout_o), .DOUT_OE_N_OUT(dout_oe_n), .LSB_FIRST_OUT(lsb_o),
		.WIRE_COUNT_SELECT_OUT(wire_o), .EARLY_RELEASE_OUT(early_o));
	serial_host_model u_host (.clk_in(ref_clk), .din_wire_in(din_wire), .dout_in(dout_wire),
		.dout_oe_n_in(dout_oe_n), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(host_din),
		.din_oe_n_out(host_oe_n));
	function automatic logic [2:0] exp_cfg(input logic [7:0] v);
		return {v[7] | v[0], v[6] | v[1], v[5] | v[2]};
	endfunction : exp_cfg
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict();
		if (miscompares == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	initial forever #12.5 ref_clk = ~ref_clk;
	initial begin
		#2000000;
		miscompares++;
		give_verdict();
	end
	initial begin
		logic [7:0] v;
		logic [7:0] rd;
		logic [2:0] c;
		logic       late;
		void'($urandom(21));
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk({5'h00, lsb_o, wire_o, early_o}, 8'h00);
		u_host.frame(8'h1F, 8'($urandom), rd, late);
		u_host.frame(8'h43, 8'h00, rd, late);
		chk(rd, UNMAPPED_READ);
		u_host.frame(8'h58, 8'h00, rd, late);
		chk(rd, 8'h00);
		for (int k = 0; k < 10; k++) begin
			v = (k < 6) ? (8'h01 << pos[k]) : 8'($urandom);
			c = exp_cfg(v & 8'hE7);
			u_host.frame(8'h18, v, rd, late);
			chk({5'h00, lsb_o, wire_o, early_o}, {5'h00, c});
			u_host.lsb   = c[2];
			u_host.two_w = c[1];
			u_host.cut   = k[0];
			u_host.frame(8'h58, 8'($urandom), rd, late);
			chk(rd, v & 8'hE7);
			chk({7'h00, late}, {7'h00, c[0]});
			chk({7'h00, dout_oe_n}, 8'h01);
			u_host.frame(8'h5F, 8'($urandom), rd, late);
			chk(rd, REV_ID_DEFAULT);
		end
		give_verdict();
	end
endmodule : serial_port_config_bench
